/* File: include/clk_sync_pkg.sv */
// Package with register map, field positions and encodings for the clock and sync select block
package clk_sync_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_SYNC_PIN_CTRL = 8'hf2;
  localparam logic [7:0] ADDR_CLK_SEL_CTRL = 8'hf3;
  localparam logic [7:0] ADDR_BP_OUT_CTRL = 8'hf1;
  localparam logic [7:0] ADDR_PORT_IO_CTRL = 8'he0;
  localparam logic [7:0] ADDR_CLK_STATUS = 8'he1;
  // Reset values
  localparam logic [7:0] RST_SYNC_PIN_CTRL = 8'h00;
  localparam logic [7:0] RST_CLK_SEL_CTRL = 8'h00;
  localparam logic [7:0] RST_BP_OUT_CTRL = 8'h00;
  localparam logic [7:0] RST_PORT_IO_CTRL = 8'h00;
  // Field positions
  localparam int SYNC_FUNC_BIT = 0;
  localparam int SYNC_DIR_BIT = 1;
  localparam int MPS_LO = 0;
  localparam int MPS_HI = 1;
  localparam int FAMILY_BIT = 2;
  localparam int REF_FREQ_BIT = 3;
  localparam int REF_SRC_LO = 4;
  localparam int REF_SRC_HI = 7;
  localparam int BP_OUT_LO = 4;
  localparam int BP_OUT_HI = 5;
  // Reference source codes
  localparam logic [3:0] REF_SRC_LAST_PORT = 4'h7;
  localparam logic [3:0] REF_SRC_MCLK = 4'h8;
  localparam logic [3:0] REF_SRC_EXT = 4'h9;
  // Reference source kind
  typedef enum logic [3:0]
  {
    SRC_PORT = 4'b0001,
    SRC_MCLK = 4'b0010,
    SRC_EXT = 4'b0100,
    SRC_NONE = 4'b1000
  } ref_kind_t;
  // Master clock base frequencies in kHz for family 0 and family 1, scaled by 2^period code
  localparam logic [15:0] MCLK_KHZ_E1_BASE = 16'h0800;
  localparam logic [15:0] MCLK_KHZ_T1_BASE = 16'h0608;
  // Backplane output base frequency in kHz
  localparam logic [15:0] BP_OUT_KHZ_BASE = 16'h0800;
  // Width in bits of the log2 master clock divide ratio to reach the base rate
  localparam int DIV_SHIFT_W = 2;
endpackage

/* File: src/ref_clk_mux.sv */
// Reference clock selector feeding the backplane clock generator
`timescale 1ns/1ps
module ref_clk_mux
#(
  parameter int PORTS = 8
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Selection
  input wire logic [3:0] refSrc,
  // Reference candidates
  input wire logic [PORTS-1:0] recoveredClk,
  input wire logic mclkRef,
  input wire logic refPinIn,
  // Result
  output logic refClk,
  output clk_sync_pkg::ref_kind_t refKind
);
  logic next_refClk;
  clk_sync_pkg::ref_kind_t next_refKind;

  always_comb
  begin
    next_refClk = 1'b0;
    next_refKind = clk_sync_pkg::SRC_NONE;
    if (refSrc <= clk_sync_pkg::REF_SRC_LAST_PORT)
    begin
      next_refClk = recoveredClk[refSrc[2:0]]; // R6
      next_refKind = clk_sync_pkg::SRC_PORT;
    end
    else if (refSrc == clk_sync_pkg::REF_SRC_MCLK)
    begin
      next_refClk = mclkRef; // R7
      next_refKind = clk_sync_pkg::SRC_MCLK;
    end
    else if (refSrc == clk_sync_pkg::REF_SRC_EXT)
    begin
      next_refClk = refPinIn; // R7
      next_refKind = clk_sync_pkg::SRC_EXT;
    end
  end

  // Registered so the selection switches glitch-free on a clock edge
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      refClk <= 1'b0;
      refKind <= clk_sync_pkg::SRC_PORT;
    end
    else
    begin
      refClk <= next_refClk; // R5
      refKind <= next_refKind;
    end
  end
endmodule

/* File: src/sync_pin_mux.sv */
// Per-port routing of the shared transmit sync pins
`timescale 1ns/1ps
module sync_pin_mux
#(
  parameter int PORTS = 8
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Control
  input wire logic funcSel,
  input wire logic dirSel,
  input wire logic [PORTS-1:0] portIoCtrl,
  input wire logic bpClkRise,
  // Sources toward the pins
  input wire logic [PORTS-1:0] portFrameSyncOut,
  input wire logic [PORTS-1:0] bpSyncOut,
  // Pins
  input wire logic [PORTS-1:0] syncPinIn,
  output logic [PORTS-1:0] syncPinOut,
  output logic [PORTS-1:0] syncPinOen,
  // Received sync toward the ports
  output logic [PORTS-1:0] portFrameSyncIn,
  output logic [PORTS-1:0] bpSyncIn
);
  genvar i;
  generate
    for (i = 0; i < PORTS; i++)
    begin : g_pin
      always_ff @(posedge sys_clk or negedge rstn)
      begin
        if (!rstn)
        begin
          syncPinOut[i] <= 1'b0;
          syncPinOen[i] <= 1'b1;
          portFrameSyncIn[i] <= 1'b0;
          bpSyncIn[i] <= 1'b0;
        end
        else if (!funcSel)
        begin
          // Port frame sync: direction from the per-port control
          syncPinOen[i] <= !portIoCtrl[i]; // R2 R3
          syncPinOut[i] <= portFrameSyncOut[i];
          portFrameSyncIn[i] <= portIoCtrl[i] ? 1'b0 : syncPinIn[i];
          bpSyncIn[i] <= 1'b0;
        end
        else
        begin
          syncPinOen[i] <= !dirSel; // R1 R2
          // Output changes only on backplane clock rising edges
          if (dirSel && bpClkRise)
          begin
            syncPinOut[i] <= bpSyncOut[i]; // R1
          end
          bpSyncIn[i] <= dirSel ? 1'b0 : syncPinIn[i];
          portFrameSyncIn[i] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule

/* File: src/global_clock_and_sync_select.sv */
// Global clock and transmit sync selection with its register file
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
// Summary of operation
// R1: With the sync direction bit at 0 the backplane sync pins are inputs, at 1 outputs timed to the backplane clock.
// R2: The sync function bit picks port frame sync (0) or backplane sync (1) for the eight shared pins.
// R3: In port frame sync mode each pin's direction comes from the per-port I/O control register.
// R4: Software should choose backplane sync on the shared pins when transmit elastic stores are on.
// R5: Bits 7 to 4 of the clock select register choose the backplane generator's reference.
// R6: Codes 0 to 7 select recovered clocks of ports 1 to 8, at the rate given by the frequency bit.
// R7: Code 8 uses a master-clock-derived reference driven on the reference pin; code 9 takes the pin as input.
// R8: Bit 3 tells the backplane generator the reference is 2.048MHz (0) or 1.544MHz (1).
// R9: Software keeps the reference frequency bit consistent with the selected port's line standard.
// R10: Bit 2 gives the master clock family: 2.048MHz-based (0) or 1.544MHz-based (1).
// R11: In family 0 period codes 0 to 3 mean 2.048, 4.096, 8.192 and 16.384 MHz.
// R12: In family 1 period codes 0 to 3 mean 1.544, 3.088, 6.176 and 12.352 MHz and timing adapts.
// R13: A two-bit backplane output field sets 2.048, 4.096, 8.192 or 16.384 MHz for codes 0 to 3.
// R14: Source codes 10 to 15 are undefined and all configuration resets to zero.
module global_clock_and_sync_select
#(
  parameter int PORTS = 8
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  // Clock references
  input wire logic [PORTS-1:0] recoveredClk,
  input wire logic mclkRef,
  input wire logic bpClkIn,
  // Reference clock pin
  input wire logic refClkPinIn,
  output logic refClkPinOut,
  output logic refClkPinOen,
  // Backplane generator controls
  output logic bpRefClk,
  output logic bpRefIs1544,
  output logic [1:0] bpOutFreqSel,
  output logic mclkIs1544,
  output logic [1:0] mclkPeriodSel,
  output logic [1:0] mclkDivShift,
  // Shared sync pins
  input wire logic [PORTS-1:0] portFrameSyncOut,
  input wire logic [PORTS-1:0] bpSyncOut,
  input wire logic [PORTS-1:0] syncPinIn,
  output logic [PORTS-1:0] syncPinOut,
  output logic [PORTS-1:0] syncPinOen,
  output logic [PORTS-1:0] portFrameSyncIn,
  output logic [PORTS-1:0] bpSyncIn
);
  logic [7:0] syncCtrl;
  logic [7:0] clkCtrl;
  logic [7:0] bpOutCtrl;
  logic [PORTS-1:0] portIoCtrl;
  logic bpClkPrev;
  logic bpClkRise;
  logic refClk;
  clk_sync_pkg::ref_kind_t refKind;
  logic [7:0] next_rdData;
  logic [7:0] statusWord;

  // Register writes; every field resets to zero
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      syncCtrl <= clk_sync_pkg::RST_SYNC_PIN_CTRL; // R14
      clkCtrl <= clk_sync_pkg::RST_CLK_SEL_CTRL; // R14
      bpOutCtrl <= clk_sync_pkg::RST_BP_OUT_CTRL;
      portIoCtrl <= PORTS'(clk_sync_pkg::RST_PORT_IO_CTRL);
    end
    else if (regWr)
    begin
      case (regAddr)
        clk_sync_pkg::ADDR_SYNC_PIN_CTRL:
        begin
          // Upper bits are reserved and kept at zero
          syncCtrl <= {6'h00, regWrData[1:0]};
        end
        clk_sync_pkg::ADDR_CLK_SEL_CTRL:
        begin
          clkCtrl <= regWrData;
        end
        clk_sync_pkg::ADDR_BP_OUT_CTRL:
        begin
          bpOutCtrl <= {2'h0, regWrData[5:4], 4'h0};
        end
        clk_sync_pkg::ADDR_PORT_IO_CTRL:
        begin
          portIoCtrl <= regWrData[PORTS-1:0];
        end
        default:
        begin
          portIoCtrl <= portIoCtrl;
        end
      endcase
    end
  end

  // Edge detect on the backplane clock sampled as a synchronous input
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bpClkPrev <= 1'b0;
      bpClkRise <= 1'b0;
    end
    else
    begin
      bpClkPrev <= bpClkIn;
      bpClkRise <= bpClkIn && !bpClkPrev;
    end
  end

  ref_clk_mux #(.PORTS(PORTS)) u_ref
  (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .refSrc(clkCtrl[clk_sync_pkg::REF_SRC_HI:clk_sync_pkg::REF_SRC_LO]),
    .recoveredClk(recoveredClk),
    .mclkRef(mclkRef),
    .refPinIn(refClkPinIn),
    .refClk(refClk),
    .refKind(refKind)
  );

  sync_pin_mux #(.PORTS(PORTS)) u_sync
  (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .funcSel(syncCtrl[clk_sync_pkg::SYNC_FUNC_BIT]),
    .dirSel(syncCtrl[clk_sync_pkg::SYNC_DIR_BIT]),
    .portIoCtrl(portIoCtrl),
    .bpClkRise(bpClkRise),
    .portFrameSyncOut(portFrameSyncOut),
    .bpSyncOut(bpSyncOut),
    .syncPinIn(syncPinIn),
    .syncPinOut(syncPinOut),
    .syncPinOen(syncPinOen),
    .portFrameSyncIn(portFrameSyncIn),
    .bpSyncIn(bpSyncIn)
  );

  // Generator controls, registered from the configuration
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bpRefClk <= 1'b0;
      bpRefIs1544 <= 1'b0;
      bpOutFreqSel <= 2'h0;
      mclkIs1544 <= 1'b0;
      mclkPeriodSel <= 2'h0;
      mclkDivShift <= 2'h0;
    end
    else
    begin
      bpRefClk <= refClk; // R5
      bpRefIs1544 <= clkCtrl[clk_sync_pkg::REF_FREQ_BIT]; // R8 R6
      bpOutFreqSel <= bpOutCtrl[clk_sync_pkg::BP_OUT_HI:clk_sync_pkg::BP_OUT_LO]; // R13
      mclkIs1544 <= clkCtrl[clk_sync_pkg::FAMILY_BIT]; // R10
      mclkPeriodSel <= clkCtrl[clk_sync_pkg::MPS_HI:clk_sync_pkg::MPS_LO]; // R11 R12
      // Divide the master clock by 2^code to reach its family's base rate
      mclkDivShift <= clkCtrl[clk_sync_pkg::MPS_HI:clk_sync_pkg::MPS_LO]; // R11 R12
    end
  end

  // Reference pin drives only when the master-derived source is chosen
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      refClkPinOut <= 1'b0;
      refClkPinOen <= 1'b1;
    end
    else
    begin
      refClkPinOen <= (refKind != clk_sync_pkg::SRC_MCLK); // R7
      refClkPinOut <= (refKind == clk_sync_pkg::SRC_MCLK) ? refClk : 1'b0; // R7
    end
  end

  // Status: bit0 source is a port, bit1 master, bit2 external, bit3 undefined code
  assign statusWord = {4'h0, refKind};

  always_comb
  begin
    case (regAddr)
      clk_sync_pkg::ADDR_SYNC_PIN_CTRL: next_rdData = syncCtrl;
      clk_sync_pkg::ADDR_CLK_SEL_CTRL: next_rdData = clkCtrl;
      clk_sync_pkg::ADDR_BP_OUT_CTRL: next_rdData = bpOutCtrl;
      clk_sync_pkg::ADDR_PORT_IO_CTRL: next_rdData = 8'(portIoCtrl);
      clk_sync_pkg::ADDR_CLK_STATUS: next_rdData = statusWord;
      default: next_rdData = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      regRdData <= 8'h00;
    end
    else
    begin
      regRdData <= regRd ? next_rdData : 8'h00;
    end
  end

  sequence s_write_ext;
    regWr && regAddr == clk_sync_pkg::ADDR_CLK_SEL_CTRL && regWrData[7:4] == clk_sync_pkg::REF_SRC_EXT;
  endsequence

  sequence s_write_mclk;
    regWr && regAddr == clk_sync_pkg::ADDR_CLK_SEL_CTRL && regWrData[7:4] == clk_sync_pkg::REF_SRC_MCLK;
  endsequence

  a_dir_input_release: assert property (@(posedge sys_clk) disable iff (!rstn) // R1
    syncCtrl[0] && !syncCtrl[1] |=> syncPinOen == '1)
    else $error("backplane sync pins not released as inputs");
  a_dir_output_drive: assert property (@(posedge sys_clk) disable iff (!rstn) // R1
    syncCtrl[0] && syncCtrl[1] |=> syncPinOen == '0)
    else $error("backplane sync pins not driven");
  a_bp_sync_edge: assert property (@(posedge sys_clk) disable iff (!rstn) // R1
    !bpClkRise && syncCtrl[0] |=> $stable(syncPinOut))
    else $error("backplane sync output changed off clock edge");
  a_port_dir_follow: assert property (@(posedge sys_clk) disable iff (!rstn) // R3
    !syncCtrl[0] |=> syncPinOen == ~$past(portIoCtrl))
    else $error("port frame sync direction ignores per-port control");
  a_func_route_in: assert property (@(posedge sys_clk) disable iff (!rstn) // R2
    syncCtrl[0] |=> portFrameSyncIn == '0)
    else $error("frame sync seen in backplane sync mode");
  a_src_ext_pin: assert property (@(posedge sys_clk) disable iff (!rstn) // R7
    s_write_ext |-> ##3 refClkPinOen)
    else $error("reference pin driven while used as input");
  a_src_mclk_pin: assert property (@(posedge sys_clk) disable iff (!rstn) // R7
    s_write_mclk ##1 !regWr[*2] |-> ##1 !refClkPinOen)
    else $error("reference pin not driven for master source");
  a_ref_port_pick: assert property (@(posedge sys_clk) disable iff (!rstn) // R6
    clkCtrl[7] == 1'b0 && $stable(clkCtrl) |=> refClk == $past(recoveredClk[clkCtrl[6:4]]))
    else $error("wrong recovered clock selected");
  a_freq_flags: assert property (@(posedge sys_clk) disable iff (!rstn) // R8
    1'b1 |=> bpRefIs1544 == $past(clkCtrl[3]) && mclkIs1544 == $past(clkCtrl[2]))
    else $error("frequency flags do not follow configuration");
  a_period_code: assert property (@(posedge sys_clk) disable iff (!rstn) // R11
    1'b1 |=> mclkPeriodSel == $past(clkCtrl[1:0]) && bpOutFreqSel == $past(bpOutCtrl[5:4]))
    else $error("period or backplane output code mismatch");
  a_div_shift: assert property (@(posedge sys_clk) disable iff (!rstn) // R12
    1'b1 |=> mclkDivShift == $past(clkCtrl[1:0]))
    else $error("master divide shift does not follow period code");

  // Reference selection, one edge behind the configuration
  a_ref_to_gen: assert property (@(posedge sys_clk) disable iff (!rstn) // R5
    1'b1 |=> bpRefClk == $past(refClk))
    else $error("generator reference does not follow selection");
  a_ref_kind_port: assert property (@(posedge sys_clk) disable iff (!rstn) // R6
    clkCtrl[7] == 1'b0 |=> refKind == clk_sync_pkg::SRC_PORT)
    else $error("port source not flagged");
  a_ref_mclk_pick: assert property (@(posedge sys_clk) disable iff (!rstn) // R7
    clkCtrl[7:4] == clk_sync_pkg::REF_SRC_MCLK |=> refClk == $past(mclkRef))
    else $error("master derived reference not selected");
  a_ref_ext_pick: assert property (@(posedge sys_clk) disable iff (!rstn) // R7
    clkCtrl[7:4] == clk_sync_pkg::REF_SRC_EXT |=> refClk == $past(refClkPinIn))
    else $error("external reference not selected");
  a_ref_undef_zero: assert property (@(posedge sys_clk) disable iff (!rstn) // R14
    clkCtrl[7:4] > clk_sync_pkg::REF_SRC_EXT |=> !refClk && refKind == clk_sync_pkg::SRC_NONE)
    else $error("undefined source code gives a reference");

  // Reference pin direction and level
  a_ref_pin_level: assert property (@(posedge sys_clk) disable iff (!rstn) // R7
    refKind == clk_sync_pkg::SRC_MCLK |=> !refClkPinOen && refClkPinOut == $past(refClk))
    else $error("reference pin does not carry master derived clock");
  a_ref_pin_quiet: assert property (@(posedge sys_clk) disable iff (!rstn) // R7
    refKind != clk_sync_pkg::SRC_MCLK |=> refClkPinOen && !refClkPinOut)
    else $error("reference pin driven for other source");

  // Backplane sync pins
  a_bp_rise_detect: assert property (@(posedge sys_clk) disable iff (!rstn) // R1
    1'b1 |=> bpClkRise == $past(bpClkIn && !bpClkPrev))
    else $error("backplane clock edge missed");
  a_bp_in_capture: assert property (@(posedge sys_clk) disable iff (!rstn) // R1
    syncCtrl[0] && !syncCtrl[1] |=> bpSyncIn == $past(syncPinIn))
    else $error("backplane sync input not captured");
  a_bp_in_hold: assert property (@(posedge sys_clk) disable iff (!rstn) // R1
    syncCtrl[0] && !syncCtrl[1] |=> $stable(syncPinOut))
    else $error("sync output moved while pins are inputs");
  a_bp_out_quiet: assert property (@(posedge sys_clk) disable iff (!rstn) // R1
    syncCtrl[0] && syncCtrl[1] |=> bpSyncIn == '0)
    else $error("backplane sync seen while pins drive");
  a_bp_out_launch: assert property (@(posedge sys_clk) disable iff (!rstn) // R1
    syncCtrl[0] && syncCtrl[1] && bpClkRise |=> syncPinOut == $past(bpSyncOut))
    else $error("backplane sync not launched on clock edge");
  a_func_route_port: assert property (@(posedge sys_clk) disable iff (!rstn) // R2
    !syncCtrl[0] |=> bpSyncIn == '0)
    else $error("backplane sync seen in frame sync mode");

  // Port frame sync pins
  a_port_frame_in: assert property (@(posedge sys_clk) disable iff (!rstn) // R3
    !syncCtrl[0] |=> portFrameSyncIn == ($past(syncPinIn) & ~$past(portIoCtrl)))
    else $error("frame sync input not taken from input pins");
  a_port_frame_out: assert property (@(posedge sys_clk) disable iff (!rstn) // R3
    !syncCtrl[0] |=> syncPinOut == $past(portFrameSyncOut))
    else $error("frame sync output not driven");

  // A configuration write reaches refKind and the generator flags and codes two edges later; bpRefClk takes three
  sequence s_write_clk;
    regWr && regAddr == clk_sync_pkg::ADDR_CLK_SEL_CTRL;
  endsequence

  sequence s_write_bp_out;
    regWr && regAddr == clk_sync_pkg::ADDR_BP_OUT_CTRL;
  endsequence

  sequence s_write_port;
    regWr && regAddr == clk_sync_pkg::ADDR_CLK_SEL_CTRL && !regWrData[7];
  endsequence

  a_write_port_kind: assert property (@(posedge sys_clk) disable iff (!rstn) // R6
    s_write_port |-> ##2 refKind == clk_sync_pkg::SRC_PORT)
    else $error("port source not taken after write");
  a_write_ext_kind: assert property (@(posedge sys_clk) disable iff (!rstn) // R7
    s_write_ext |-> ##2 refKind == clk_sync_pkg::SRC_EXT)
    else $error("external source not taken after write");
  a_write_mclk_kind: assert property (@(posedge sys_clk) disable iff (!rstn) // R7
    s_write_mclk |-> ##2 refKind == clk_sync_pkg::SRC_MCLK)
    else $error("master source not taken after write");
  a_write_ref_freq: assert property (@(posedge sys_clk) disable iff (!rstn) // R8
    s_write_clk |-> ##2 bpRefIs1544 == $past(regWrData[3], 2))
    else $error("reference rate flag not taken after write");
  a_write_family: assert property (@(posedge sys_clk) disable iff (!rstn) // R10
    s_write_clk |-> ##2 mclkIs1544 == $past(regWrData[2], 2))
    else $error("master family flag not taken after write");
  a_write_period: assert property (@(posedge sys_clk) disable iff (!rstn) // R11
    s_write_clk |-> ##2 mclkPeriodSel == $past(regWrData[1:0], 2))
    else $error("master period code not taken after write");
  a_write_bp_out: assert property (@(posedge sys_clk) disable iff (!rstn) // R13
    s_write_bp_out |-> ##2 bpOutFreqSel == $past(regWrData[5:4], 2))
    else $error("backplane output code not taken after write");
endmodule

/* File: bench/backplane_peer.sv */
// Backplane peer: shared backplane clock, remote sync drivers and an external reference
`timescale 1ns/1ps
module backplane_peer
(
  // Clock
  input wire logic sys_clk,
  // Bench control
  input wire logic bpRun,
  input wire logic [7:0] farSync,
  input wire logic farRef,
  // Device pins
  input wire logic [7:0] syncPinOut,
  input wire logic [7:0] syncPinOen,
  input wire logic refClkPinOut,
  input wire logic refClkPinOen,
  output logic bpClkIn,
  output logic [7:0] syncPinIn,
  output logic refClkPinIn
);
  logic [1:0] div = 2'h0;
  // Clock stands still low while stopped, so no stray rise reaches the device
  always @(posedge sys_clk)
  begin
    div <= div + 2'h1;
    if (!bpRun)
      bpClkIn <= 1'b0;
    else if (div == 2'h3)
      bpClkIn <= ~bpClkIn;
  end
  // Oen low means the device drives the wire, otherwise the peer does
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      syncPinIn[i] = syncPinOen[i] ? farSync[i] : syncPinOut[i];
    refClkPinIn = refClkPinOen ? farRef : refClkPinOut;
  end
endmodule

/* File: bench/global_clock_and_sync_select_bench.sv */
// Self-checking bench for the clock and sync select block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin err_total++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module global_clock_and_sync_select_bench;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdData;
  logic [7:0] recoveredClk = 8'h00;
  logic mclkRef = 1'b0;
  logic bpClkIn, refClkPinIn, refClkPinOut, refClkPinOen, bpRefClk, bpRefIs1544, mclkIs1544;
  logic [1:0] bpOutFreqSel, mclkPeriodSel, mclkDivShift;
  logic [7:0] portFrameSyncOut = 8'h00;
  logic [7:0] bpSyncOut = 8'h00;
  logic [7:0] syncPinIn, syncPinOut, syncPinOen, portFrameSyncIn, bpSyncIn;
  logic bpRun = 1'b0;
  logic [7:0] farSync = 8'h00;
  logic farRef = 1'b0;
  logic rdPend = 1'b0;
  logic [7:0] ex, d;
  logic [31:0] r;
  logic [3:0] kind;
  logic e;
  int c, seed = 37, err_total = 0, tests_run = 0;
  logic [7:0] expQ[$];
  logic [7:0] addrs [5] = '{clk_sync_pkg::ADDR_CLK_SEL_CTRL, clk_sync_pkg::ADDR_SYNC_PIN_CTRL,
    clk_sync_pkg::ADDR_BP_OUT_CTRL, clk_sync_pkg::ADDR_PORT_IO_CTRL, 8'h55};
  logic [7:0] masks [5] = '{8'hff, 8'h03, 8'h30, 8'hff, 8'h00};

  always #2.5 sys_clk = ~sys_clk;

  global_clock_and_sync_select dut
  (
    .sys_clk(sys_clk), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .recoveredClk(recoveredClk), .mclkRef(mclkRef),
    .bpClkIn(bpClkIn), .refClkPinIn(refClkPinIn), .refClkPinOut(refClkPinOut),
    .refClkPinOen(refClkPinOen), .bpRefClk(bpRefClk), .bpRefIs1544(bpRefIs1544),
    .bpOutFreqSel(bpOutFreqSel), .mclkIs1544(mclkIs1544), .mclkPeriodSel(mclkPeriodSel),
    .mclkDivShift(mclkDivShift), .portFrameSyncOut(portFrameSyncOut), .bpSyncOut(bpSyncOut),
    .syncPinIn(syncPinIn), .syncPinOut(syncPinOut), .syncPinOen(syncPinOen),
    .portFrameSyncIn(portFrameSyncIn), .bpSyncIn(bpSyncIn)
  );

  backplane_peer peer
  (
    .sys_clk(sys_clk), .bpRun(bpRun), .farSync(farSync), .farRef(farRef),
    .syncPinOut(syncPinOut), .syncPinOen(syncPinOen), .refClkPinOut(refClkPinOut),
    .refClkPinOen(refClkPinOen), .bpClkIn(bpClkIn), .syncPinIn(syncPinIn),
    .refClkPinIn(refClkPinIn)
  );

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= v;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    regRd <= 1'b1;
    regAddr <= a;
    expQ.push_back(v);
    @(posedge sys_clk);
    regRd <= 1'b0;
  endtask

  task automatic settle;
    repeat (5) @(posedge sys_clk);
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge sys_clk)
  begin
    if (rdPend)
    begin
      ex = expQ.pop_front();
      `CHK("regRdData", ex, regRdData)
    end
    rdPend <= regRd;
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    final_report;
  end

  initial
  begin
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    foreach (addrs[i])
      rd(addrs[i], 8'h00);
    `CHK("refClkPinOen", 1'b1, refClkPinOen)
    $display("test reset done");
    for (c = 0; c < 6; c++)
      foreach (addrs[i])
      begin
        d = $random(seed);
        wr(addrs[i], d);
        rd(addrs[i], d & masks[i]);
      end
    $display("test registers done");
    for (c = 0; c < 16; c++)
    begin
      wr(clk_sync_pkg::ADDR_CLK_SEL_CTRL, {4'h0, c[3:0]});
      wr(clk_sync_pkg::ADDR_BP_OUT_CTRL, {2'h0, c[1:0], 4'h0});
      settle;
      `CHK("bpRefIs1544", c[3], bpRefIs1544)
      `CHK("mclkIs1544", c[2], mclkIs1544)
      `CHK("mclkPeriodSel", c[1:0], mclkPeriodSel)
      `CHK("mclkDivShift", c[1:0], mclkDivShift)
      `CHK("bpOutFreqSel", c[1:0], bpOutFreqSel)
    end
    $display("test clock fields done");
    for (c = 0; c < 32; c++)
    begin
      wr(clk_sync_pkg::ADDR_CLK_SEL_CTRL, {c[3:0], 4'h0});
      r = $random(seed);
      recoveredClk <= r[7:0];
      mclkRef <= r[8];
      farRef <= r[9];
      settle;
      e = c[3:0] < 4'h8 ? recoveredClk[c[2:0]] : c[3:0] == 4'h8 ? mclkRef : c[3:0] == 4'h9 && farRef;
      `CHK("bpRefClk", e, bpRefClk)
      `CHK("refClkPinOen", c[3:0] != 4'h8, refClkPinOen)
      if (c[3:0] == 4'h8)
        `CHK("refClkPinOut", mclkRef, refClkPinOut)
      kind = c[3:0] < 4'h8 ? 4'h1 : c[3:0] == 4'h8 ? 4'h2 : c[3:0] == 4'h9 ? 4'h4 : 4'h8;
      rd(clk_sync_pkg::ADDR_CLK_STATUS, {4'h0, kind});
    end
    $display("test reference done");
    bpRun <= 1'b1;
    for (c = 0; c < 8; c++)
    begin
      r = $random(seed);
      wr(clk_sync_pkg::ADDR_PORT_IO_CTRL, r[7:0]);
      wr(clk_sync_pkg::ADDR_SYNC_PIN_CTRL, {6'h0, c[1:0]});
      portFrameSyncOut <= r[15:8];
      bpSyncOut <= r[23:16];
      farSync <= r[31:24];
      repeat (12) @(posedge sys_clk);
      if (!c[0])
      begin
        `CHK("syncPinOen", ~r[7:0], syncPinOen)
        `CHK("syncPinOut", r[15:8] & r[7:0], syncPinOut & r[7:0])
        `CHK("portFrameSyncIn", r[31:24] & ~r[7:0], portFrameSyncIn)
        `CHK("bpSyncIn", 8'h00, bpSyncIn)
      end
      else
      begin
        `CHK("syncPinOen", {8{~c[1]}}, syncPinOen)
        `CHK("bpSyncIn", c[1] ? 8'h00 : r[31:24], bpSyncIn)
        `CHK("portFrameSyncIn", 8'h00, portFrameSyncIn)
        if (c[1])
          `CHK("syncPinOut", r[23:16], syncPinOut)
      end
    end
    // Stop the backplane clock before changing the source so no rise can race it
    bpRun <= 1'b0;
    repeat (4) @(posedge sys_clk);
    d = bpSyncOut;
    bpSyncOut <= ~d;
    repeat (12) @(posedge sys_clk);
    `CHK("syncPinOut", d, syncPinOut)
    bpRun <= 1'b1;
    repeat (12) @(posedge sys_clk);
    `CHK("syncPinOut", ~d, syncPinOut)
    $display("test sync pins done");
    final_report;
  end
endmodule
